// ==== rtl/bridge_fault_map.svh ====
// Behaviour
// - Read-only verify flags: phase states, amp unplugged
// - Every frame word holds odd ones
// - Mask 1 suppresses fault; masks reset 0
// - Diag word 0 reports gate source undervoltage
// - Diag word 1: regulator, drain-source overvoltage
// - Diag word 2: supply, bootstrap, overcurrent, open
// - Boot manager off bit: 0 active
// - Stop-on-fault bit halts bridge; faults always reported
// - Control word holds four gate commands
// - Status powers up with summary, reset flags
// - Status word read-only fault flags
// - Summary flags OR their diagnostic bits
// - Some status flags driven directly, no diag
// - Phase A: high input active high, low active low
// - Phase B: polarities opposite to phase A
// - Dead timer per phase prevents cross-conduction
`ifndef BRIDGE_FAULT_MAP_SVH
`define BRIDGE_FAULT_MAP_SVH

// ************************************************************
// Frame layout
// ************************************************************
`define FRAME_ADDR_MSB 15
`define FRAME_ADDR_LSB 12
`define FRAME_WR_BIT 11
`define FRAME_DATA_MSB 10
`define FRAME_DATA_LSB 1
`define FRAME_PARITY_BIT 0
`define FRAME_BITS 16

// ************************************************************
// Register offsets
// ************************************************************
`define VERIFICATION_RESULT_B_ADDR 4'h9
`define FAULT_MASK_LOW_ADDR 4'hA
`define FAULT_MASK_HIGH_ADDR 4'hB
`define GATE_UNDERVOLTAGE_FAULTS_ADDR 4'hC
`define OVERVOLTAGE_FAULTS_ADDR 4'hD
`define SUPPLY_LOAD_FAULTS_ADDR 4'hE
`define BRIDGE_CONTROL_ADDR 4'hF

// ************************************************************
// Field positions
// ************************************************************
`define GATE_MSB 4
`define GATE_LSB 1
`define BOOT_LOW_MASK_BIT 8
`define HEAT_WARNING_BIT 7
`define REGULATOR_HIGH_BIT 10
`define REGULATOR_LOW_BIT 9
`define SUPPLY_RANGE_BIT 8
`define LOGIC_SUPPLY_HIGH_BIT 7
`define SUPPLY_HIGH_BIT 10
`define SUPPLY_LOW_BIT 9
`define PHASE_B_BOOT_BIT 7
`define PHASE_A_BOOT_BIT 6
`define PHASE_B_OC_BIT 3
`define PHASE_A_OC_BIT 2
`define LOAD_OPEN_BIT 1
`define BOOT_MANAGER_OFF_BIT 8
`define HALT_ON_FAULT_BIT 7
`define PHASE_B_LEVEL_BIT 5
`define PHASE_A_LEVEL_BIT 4
`define AMP_UNPLUGGED_BIT 1
`define ST_DIAG_SUMMARY_BIT 15
`define ST_POWER_ON_BIT 14
`define ST_FRAME_ERROR_BIT 13
`define ST_OVERTEMP_BIT 11
`define ST_HEAT_WARNING_BIT 10
`define ST_SUPPLY_RANGE_BIT 9
`define ST_LOGIC_HIGH_BIT 8
`define ST_ENABLE_TIMEOUT_BIT 7
`define ST_REGULATOR_RANGE_BIT 6
`define ST_LOAD_FAULT_BIT 4
`define ST_BOOT_LOW_BIT 3
`define ST_GATE_SRC_LOW_BIT 2
`define ST_DRAIN_SRC_HIGH_BIT 1

// ************************************************************
// Writable bits and reset values
// ************************************************************
`define FAULT_MASK_LOW_WR 16'h019E
`define FAULT_MASK_HIGH_WR 16'h079E
`define BRIDGE_CONTROL_WR 16'h019E
`define FAULT_MASK_RESET 16'h0000
`define BRIDGE_CONTROL_RESET 16'h0080
`define STATUS_RESET 16'hC000
`define TX_RESET 16'hC001

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS 10
`define DEAD_TIME_NS 100
`define DEAD_CYCLES ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== rtl/bridge_fault_pkg.sv ====
package bridge_fault_pkg;

  typedef logic [15:0] word_type;
  typedef logic [3:0] addr_type;
  typedef logic [3:0] gate_set_type;

  // True when the word holds an odd count of ones
  function automatic logic odd_ones(input word_type w);
    return ^w;
  endfunction

  // Fill the parity bit so the whole word has odd ones
  function automatic word_type with_parity(input word_type w);
    word_type r;
    r = w;
    r[0] = ~(^w[15:1]);
    return r;
  endfunction

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  if (W < 1) begin : g_chk
    $error("pin_sync width must be at least one");
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A bit changes only once two late stages agree
      level_out <= (s2_r & s3_r) | (level_out & (s2_r | s3_r));
    end
  end
endmodule

// ==== rtl/dead_timer.sv ====
`timescale 1ns/100ps
`include "bridge_fault_map.svh"
module dead_timer #(
  parameter int DEAD_CYCLES = `DEAD_CYCLES,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hi_req,
  input wire logic lo_req,
  output logic hi_gate,
  output logic lo_gate
);
  logic [CNT_W-1:0] wait_r;
  logic want_hi;
  logic want_lo;

  if (DEAD_CYCLES < 1 || DEAD_CYCLES >= (1 << CNT_W)) begin : g_chk
    $error("dead_timer count does not fit its counter");
  end

  // Both requests at once mean neither gate, never both
  assign want_hi = hi_req & ~lo_req;
  assign want_lo = lo_req & ~hi_req;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_gate <= 1'b0;
      lo_gate <= 1'b0;
      wait_r <= '0;
    end else begin
      if (!want_hi) begin
        hi_gate <= 1'b0;
      end
      if (!want_lo) begin
        lo_gate <= 1'b0;
      end
      if ((hi_gate && !want_hi) || (lo_gate && !want_lo)) begin
        wait_r <= CNT_W'(DEAD_CYCLES);
      end else if (wait_r != '0) begin
        wait_r <= wait_r - 1'b1;
      end else begin
        if (want_hi) begin
          hi_gate <= 1'b1;
        end
        if (want_lo) begin
          lo_gate <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== rtl/bridge_driver_fault_regs.sv ====
`timescale 1ns/100ps
`include "bridge_fault_map.svh"
module bridge_driver_fault_regs
  import bridge_fault_pkg::*;
#(
  parameter int DEAD_CYCLES = `DEAD_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic heat_warning_in,
  input wire logic overtemp_in,
  input wire logic logic_supply_high_in,
  input wire logic enable_pin_timeout_in,
  input wire logic regulator_high_in,
  input wire logic regulator_low_in,
  input wire logic supply_high_in,
  input wire logic supply_low_in,
  input wire logic phase_b_boot_low_in,
  input wire logic phase_a_boot_low_in,
  input wire logic phase_b_overcurrent_in,
  input wire logic phase_a_overcurrent_in,
  input wire logic load_open_in,
  input wire logic [3:0] gate_src_low_in,
  input wire logic [3:0] drain_src_high_in,
  input wire logic phase_b_level_in,
  input wire logic phase_a_level_in,
  input wire logic amp_unplugged_in,
  input wire logic a_hi_ctl,
  input wire logic a_lo_ctl_n,
  input wire logic b_hi_ctl_n,
  input wire logic b_lo_ctl,
  output logic a_hi_gate,
  output logic a_lo_gate,
  output logic b_hi_gate,
  output logic b_lo_gate,
  output logic boot_manager_en,
  output logic bridge_stopped
);

  // ************************************************************
  // Link domain: shift in on rising sck
  // ************************************************************
  localparam int SYNC_W = 31;
  // Pins start at their idle levels, so no gate is requested just after reset
  localparam logic [SYNC_W-1:0] SYNC_RESET = {1'b1, 2'b00, 4'b0110, 24'h000000};

  logic [4:0] bit_cnt_r;
  logic [14:0] shift_r;
  word_type rx_word_r;
  logic word_tgl_r;
  logic over_tgl_r;
  word_type tx_word_r;

  // Counter is cleared while the select is high, so every frame starts clean
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_r <= '0;
    end else if (bit_cnt_r != 5'd17) begin
      bit_cnt_r <= bit_cnt_r + 5'd1;
    end
  end

  always_ff @(posedge spi_sck or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= '0;
      rx_word_r <= '0;
      word_tgl_r <= 1'b0;
      over_tgl_r <= 1'b0;
    end else begin
      if (bit_cnt_r < 5'd15) begin
        shift_r <= {shift_r[13:0], spi_sdi};
      end
      if (bit_cnt_r == 5'd15) begin
        rx_word_r <= {shift_r, spi_sdi};
        word_tgl_r <= ~word_tgl_r;
      end
      if (bit_cnt_r == 5'd16) begin
        over_tgl_r <= ~over_tgl_r;
      end
    end
  end

  // The answer word only changes after the select has gone high,
  // while sck stands still, so it is static for the whole frame.
  assign spi_sdo = (bit_cnt_r < 5'd16) ? tx_word_r[4'd15 - bit_cnt_r[3:0]] : 1'b0;
  assign spi_sdo_oe = ~spi_cs_n;

  // ************************************************************
  // Pin and link synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] sync_s;
  logic cs_s;
  logic word_tgl_s;
  logic over_tgl_s;
  logic a_hi_s;
  logic a_lo_n_s;
  logic b_hi_n_s;
  logic b_lo_s;
  logic heat_s;
  logic overtemp_s;
  logic logic_high_s;
  logic en_timeout_s;
  logic reg_high_s;
  logic reg_low_s;
  logic sup_high_s;
  logic sup_low_s;
  logic b_boot_s;
  logic a_boot_s;
  logic b_oc_s;
  logic a_oc_s;
  logic open_s;
  logic [3:0] gsl_s;
  logic [3:0] dsh_s;
  logic b_level_s;
  logic a_level_s;
  logic amp_s;

  pin_sync #(
    .W(SYNC_W),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in({spi_cs_n, word_tgl_r, over_tgl_r, a_hi_ctl, a_lo_ctl_n, b_hi_ctl_n,
             b_lo_ctl, heat_warning_in, overtemp_in, logic_supply_high_in,
             enable_pin_timeout_in, regulator_high_in, regulator_low_in,
             supply_high_in, supply_low_in, phase_b_boot_low_in, phase_a_boot_low_in,
             phase_b_overcurrent_in, phase_a_overcurrent_in, load_open_in,
             gate_src_low_in, drain_src_high_in, phase_b_level_in,
             phase_a_level_in, amp_unplugged_in}),
    .level_out(sync_s)
  );

  assign {cs_s, word_tgl_s, over_tgl_s, a_hi_s, a_lo_n_s, b_hi_n_s, b_lo_s, heat_s,
          overtemp_s, logic_high_s, en_timeout_s, reg_high_s, reg_low_s, sup_high_s,
          sup_low_s, b_boot_s, a_boot_s, b_oc_s, a_oc_s, open_s, gsl_s, dsh_s,
          b_level_s, a_level_s, amp_s} = sync_s;

  // ************************************************************
  // Frame tracking in the system domain
  // ************************************************************
  logic word_seen_r;
  logic over_seen_r;
  logic cs_prev_r;
  logic pending_r;
  logic over_r;
  logic new_word;
  logic over_evt;
  logic frame_end;
  logic frame_ok;
  logic frame_wr;
  addr_type frame_addr;

  assign new_word = word_tgl_s ^ word_seen_r;
  assign over_evt = over_tgl_s ^ over_seen_r;
  assign frame_end = cs_s & ~cs_prev_r;
  // Short, long or wrong-parity frames are all refused
  assign frame_ok = (pending_r | new_word) & ~over_r & ~over_evt & odd_ones(rx_word_r);
  assign frame_wr = rx_word_r[`FRAME_WR_BIT];
  assign frame_addr = rx_word_r[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_seen_r <= 1'b0;
      over_seen_r <= 1'b0;
      cs_prev_r <= 1'b1;
      pending_r <= 1'b0;
      over_r <= 1'b0;
    end else begin
      word_seen_r <= word_tgl_s;
      over_seen_r <= over_tgl_s;
      cs_prev_r <= cs_s;
      if (!cs_s && cs_prev_r) begin
        pending_r <= 1'b0;
        over_r <= 1'b0;
      end else begin
        if (new_word) begin
          pending_r <= 1'b1;
        end
        if (over_evt) begin
          over_r <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Writable registers
  // ************************************************************
  word_type mask_low_r;
  word_type mask_high_r;
  word_type control_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_low_r <= `FAULT_MASK_RESET;
      mask_high_r <= `FAULT_MASK_RESET;
      control_r <= `BRIDGE_CONTROL_RESET;
    end else if (frame_end && frame_ok && frame_wr) begin
      unique case (frame_addr)
        `FAULT_MASK_LOW_ADDR: mask_low_r <= rx_word_r & `FAULT_MASK_LOW_WR;
        `FAULT_MASK_HIGH_ADDR: mask_high_r <= rx_word_r & `FAULT_MASK_HIGH_WR;
        `BRIDGE_CONTROL_ADDR: control_r <= rx_word_r & `BRIDGE_CONTROL_WR;
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Masked faults and diagnostic words
  // ************************************************************
  logic [3:0] gsl_m;
  logic [3:0] dsh_m;
  logic reg_high_m;
  logic reg_low_m;
  logic sup_high_m;
  logic sup_low_m;
  logic b_boot_m;
  logic a_boot_m;
  logic heat_m;
  logic logic_high_m;
  logic overcurrent_any;
  word_type diag0_w;
  word_type diag1_w;
  word_type diag2_w;
  word_type verify_w;

  // A masked fault never reaches a diag bit nor its summary flag
  assign gsl_m = gsl_s & ~mask_low_r[`GATE_MSB:`GATE_LSB];
  assign dsh_m = dsh_s & ~mask_high_r[`GATE_MSB:`GATE_LSB];
  assign reg_high_m = reg_high_s & ~mask_high_r[`REGULATOR_HIGH_BIT];
  assign reg_low_m = reg_low_s & ~mask_high_r[`REGULATOR_LOW_BIT];
  assign sup_high_m = sup_high_s & ~mask_high_r[`SUPPLY_RANGE_BIT];
  assign sup_low_m = sup_low_s & ~mask_high_r[`SUPPLY_RANGE_BIT];
  assign b_boot_m = b_boot_s & ~mask_low_r[`BOOT_LOW_MASK_BIT];
  assign a_boot_m = a_boot_s & ~mask_low_r[`BOOT_LOW_MASK_BIT];
  assign heat_m = heat_s & ~mask_low_r[`HEAT_WARNING_BIT];
  assign logic_high_m = logic_high_s & ~mask_high_r[`LOGIC_SUPPLY_HIGH_BIT];
  assign overcurrent_any = b_oc_s | a_oc_s;

  always_comb begin
    diag0_w = '0;
    diag1_w = '0;
    diag2_w = '0;
    verify_w = '0;
    diag0_w[`GATE_MSB:`GATE_LSB] = gsl_m;
    diag1_w[`REGULATOR_HIGH_BIT] = reg_high_m;
    diag1_w[`REGULATOR_LOW_BIT] = reg_low_m;
    diag1_w[`GATE_MSB:`GATE_LSB] = dsh_m;
    diag2_w[`SUPPLY_HIGH_BIT] = sup_high_m;
    diag2_w[`SUPPLY_LOW_BIT] = sup_low_m;
    diag2_w[`PHASE_B_BOOT_BIT] = b_boot_m;
    diag2_w[`PHASE_A_BOOT_BIT] = a_boot_m;
    diag2_w[`PHASE_B_OC_BIT] = b_oc_s;
    diag2_w[`PHASE_A_OC_BIT] = a_oc_s;
    diag2_w[`LOAD_OPEN_BIT] = open_s;
    verify_w[`PHASE_B_LEVEL_BIT] = b_level_s;
    verify_w[`PHASE_A_LEVEL_BIT] = a_level_s;
    verify_w[`AMP_UNPLUGGED_BIT] = amp_s;
  end

  // ************************************************************
  // Status word
  // ************************************************************
  logic power_on_r;
  logic frame_error_r;
  logic tx_status_r;
  logic power_on_nxt;
  logic frame_error_nxt;
  logic status_taken;
  word_type status_w;

  // Flags clear once a good frame has carried them out; a new error wins
  assign status_taken = frame_end & frame_ok & tx_status_r;
  assign power_on_nxt = power_on_r & ~status_taken;
  assign frame_error_nxt = (frame_end & ~frame_ok) | (frame_error_r & ~status_taken);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_on_r <= 1'b1;
      frame_error_r <= 1'b0;
    end else begin
      power_on_r <= power_on_nxt;
      frame_error_r <= frame_error_nxt;
    end
  end

  always_comb begin
    status_w = '0;
    status_w[`ST_DIAG_SUMMARY_BIT] = power_on_nxt | (|diag0_w) | (|diag1_w) | (|diag2_w);
    status_w[`ST_POWER_ON_BIT] = power_on_nxt;
    status_w[`ST_FRAME_ERROR_BIT] = frame_error_nxt;
    status_w[`ST_OVERTEMP_BIT] = overtemp_s;
    status_w[`ST_HEAT_WARNING_BIT] = heat_m;
    status_w[`ST_SUPPLY_RANGE_BIT] = sup_high_m | sup_low_m;
    status_w[`ST_LOGIC_HIGH_BIT] = logic_high_m;
    status_w[`ST_ENABLE_TIMEOUT_BIT] = en_timeout_s;
    status_w[`ST_REGULATOR_RANGE_BIT] = reg_high_m | reg_low_m;
    status_w[`ST_LOAD_FAULT_BIT] = overcurrent_any | open_s;
    status_w[`ST_BOOT_LOW_BIT] = b_boot_m | a_boot_m;
    status_w[`ST_GATE_SRC_LOW_BIT] = |gsl_m;
    status_w[`ST_DRAIN_SRC_HIGH_BIT] = |dsh_m;
  end

  // ************************************************************
  // Read-back and answer word
  // ************************************************************
  word_type rd_val;
  logic rd_hit;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case (frame_addr)
      `VERIFICATION_RESULT_B_ADDR: rd_val = verify_w;
      `FAULT_MASK_LOW_ADDR: rd_val = mask_low_r;
      `FAULT_MASK_HIGH_ADDR: rd_val = mask_high_r;
      `GATE_UNDERVOLTAGE_FAULTS_ADDR: rd_val = diag0_w;
      `OVERVOLTAGE_FAULTS_ADDR: rd_val = diag1_w;
      `SUPPLY_LOAD_FAULTS_ADDR: rd_val = diag2_w;
      `BRIDGE_CONTROL_ADDR: rd_val = control_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // A good read answers with the register in the next frame; anything
  // else answers with status. The answer is a frame behind by design.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_word_r <= `TX_RESET;
      tx_status_r <= 1'b1;
    end else if (frame_end) begin
      if (frame_ok && !frame_wr && rd_hit) begin
        tx_word_r <= with_parity({frame_addr, 1'b0,
                                  rd_val[`FRAME_DATA_MSB:`FRAME_DATA_LSB], 1'b0});
        tx_status_r <= 1'b0;
      end else begin
        tx_word_r <= with_parity(status_w);
        tx_status_r <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Bridge control
  // ************************************************************
  logic fault_any;
  gate_set_type cmd;
  logic a_hi_req;
  logic a_lo_req;
  logic b_hi_req;
  logic b_lo_req;

  // Warning-level flags do not stop the bridge
  assign fault_any = status_w[`ST_OVERTEMP_BIT] | status_w[`ST_SUPPLY_RANGE_BIT] |
                     status_w[`ST_LOGIC_HIGH_BIT] | status_w[`ST_ENABLE_TIMEOUT_BIT] |
                     status_w[`ST_REGULATOR_RANGE_BIT] | status_w[`ST_LOAD_FAULT_BIT] |
                     status_w[`ST_BOOT_LOW_BIT] | status_w[`ST_GATE_SRC_LOW_BIT] |
                     status_w[`ST_DRAIN_SRC_HIGH_BIT];
  assign bridge_stopped = control_r[`HALT_ON_FAULT_BIT] & fault_any;
  assign boot_manager_en = ~control_r[`BOOT_MANAGER_OFF_BIT];
  assign cmd = control_r[`GATE_MSB:`GATE_LSB];

  // Command bits order: phase B high, B low, A high, A low
  assign a_hi_req = ~bridge_stopped & (a_hi_s | cmd[1]);
  assign a_lo_req = ~bridge_stopped & (~a_lo_n_s | cmd[0]);
  assign b_hi_req = ~bridge_stopped & (~b_hi_n_s | cmd[3]);
  assign b_lo_req = ~bridge_stopped & (b_lo_s | cmd[2]);

  dead_timer #(
    .DEAD_CYCLES(DEAD_CYCLES)
  ) u_dead_a (
    .clk(clk),
    .reset_n(reset_n),
    .hi_req(a_hi_req),
    .lo_req(a_lo_req),
    .hi_gate(a_hi_gate),
    .lo_gate(a_lo_gate)
  );

  dead_timer #(
    .DEAD_CYCLES(DEAD_CYCLES)
  ) u_dead_b (
    .clk(clk),
    .reset_n(reset_n),
    .hi_req(b_hi_req),
    .lo_req(b_lo_req),
    .hi_gate(b_hi_gate),
    .lo_gate(b_lo_gate)
  );

endmodule

// ==== test/fault_regs_asserts.sv ====
`timescale 1ns/100ps
// ****************************************
// Gate and link checks
// ****************************************
module fault_regs_asserts #(
  parameter int DEAD_CYCLES = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic a_hi_gate,
  input wire logic a_lo_gate,
  input wire logic b_hi_gate,
  input wire logic b_lo_gate,
  input wire logic boot_manager_en,
  input wire logic bridge_stopped
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence stop_s;
    bridge_stopped [*3];
  endsequence
  sequence off_s;
    !(a_hi_gate || a_lo_gate || b_hi_gate || b_lo_gate);
  endsequence
  // Dead gap checked as 3 cycles, so it only bites when DEAD_CYCLES is at least 2
  a_excl_a: assert property (!(a_hi_gate && a_lo_gate)) else $error("phase A both on");
  b_excl_a: assert property (!(b_hi_gate && b_lo_gate)) else $error("phase B both on");
  a_dead_a: assert property ($fell(a_hi_gate) |-> !a_lo_gate [*3])
    else $error("phase A dead gap short");
  b_dead_a: assert property ($fell(b_lo_gate) |-> !b_hi_gate [*3])
    else $error("phase B dead gap short");
  stop_gates_a: assert property (stop_s |-> off_s) else $error("gates on while stopped");
  reset_boot_a: assert property ($rose(reset_n) |-> boot_manager_en)
    else $error("boot manager off after reset");
  reset_gates_a: assert property ($rose(reset_n) |-> off_s) else $error("gate on after reset");
  link_oe_a: assert property (spi_sdo_oe == !spi_cs_n) else $error("sdo enable wrong");
endmodule
bind bridge_driver_fault_regs fault_regs_asserts #(.DEAD_CYCLES(DEAD_CYCLES)) chk_i (
  .clk(clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
  .a_hi_gate(a_hi_gate), .a_lo_gate(a_lo_gate), .b_hi_gate(b_hi_gate), .b_lo_gate(b_lo_gate),
  .boot_manager_en(boot_manager_en), .bridge_stopped(bridge_stopped));

// ==== test/spi_host.sv ====
`timescale 1ns/100ps
module spi_host
  import bridge_fault_pkg::*;
(
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  // ****************************************
  // Frame master
  // ****************************************
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    // A late first edge on the select clears the bit counter for sure
    #1 cs_n = 1'b1;
  end
  // Clock only inside frames; sdi flips after release so a stale bit never looks valid
  task automatic xfer(input word_type w, input logic bad, output word_type r);
    word_type t;
    t = {w[15:1], ~^w[15:1] ^ bad};
    #3 cs_n = 1'b0;
    #80;
    for (int i = 15; i >= 0; i--) begin
      sdi = t[i];
      #75 r[i] = sdo;
      sck = 1'b1;
      #80 sck = 1'b0;
      #5;
    end
    cs_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

// ==== test/bridge_driver_fault_regs_tb.sv ====
`timescale 1ns/100ps
module bridge_driver_fault_regs_tb;
  import bridge_fault_pkg::*;
  logic clk, reset_n, sck, cs_n, sdi, sdo, oe, bme, stp;
  logic [12:0] flt;
  logic [3:0] gsl, dsh, pin, g;
  logic [2:0] ver;
  word_type rx;
  int error_cnt, checks;
  // ****************************************
  // Harness
  // ****************************************
  bridge_driver_fault_regs #(.DEAD_CYCLES(3)) uut (
    .clk(clk), .reset_n(reset_n), .spi_sck(sck), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .spi_sdo(sdo), .spi_sdo_oe(oe), .heat_warning_in(flt[0]), .overtemp_in(flt[1]),
    .logic_supply_high_in(flt[2]), .enable_pin_timeout_in(flt[3]), .regulator_high_in(flt[4]),
    .regulator_low_in(flt[5]), .supply_high_in(flt[6]), .supply_low_in(flt[7]),
    .phase_b_boot_low_in(flt[8]), .phase_a_boot_low_in(flt[9]),
    .phase_b_overcurrent_in(flt[10]), .phase_a_overcurrent_in(flt[11]),
    .load_open_in(flt[12]), .gate_src_low_in(gsl), .drain_src_high_in(dsh),
    .phase_b_level_in(ver[2]), .phase_a_level_in(ver[1]), .amp_unplugged_in(ver[0]),
    .a_hi_ctl(pin[3]), .a_lo_ctl_n(pin[2]), .b_hi_ctl_n(pin[1]), .b_lo_ctl(pin[0]),
    .a_hi_gate(g[3]), .a_lo_gate(g[2]), .b_hi_gate(g[1]), .b_lo_gate(g[0]),
    .boot_manager_en(bme), .bridge_stopped(stp));
  spi_host host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input word_type s, input word_type e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic word_type pw(input word_type w);
    return {w[15:1], ~^w[15:1]};
  endfunction
  // Answer of each frame belongs to the frame before it
  task automatic x(input word_type w, input logic bad = 1'b0);
    host.xfer(w, bad, rx);
    chk("rx parity", word_type'(^rx), 16'h0001);
    repeat (30) @(negedge clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    results;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {flt, gsl, dsh, ver} = '0;
    pin = 4'b0110;
    // Reset falls after time zero so no process can miss the edge
    #1 reset_n = 1'b0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    for (int v = 0; v < 3; v++) begin
      pin = {4{v[0]}};
      repeat (20) @(negedge clk);
      chk("pwm gates", word_type'(g), v[0] ? 16'h0009 : 16'h0006);
    end
    pin = 4'b0110;
    x(16'hF000);
    chk("power-on status", rx, pw(16'hC000));
    x(16'hF88C);
    chk("control reset", rx, pw(16'hF080));
    chk("cmd gates", word_type'(g), 16'h0009);
    x(16'hA99E);
    x(16'hA000);
    {flt, gsl, dsh, ver} = {13'h1FFF, 4'hF, 4'h5, 3'h7};
    repeat (10) @(negedge clk);
    chk("stop gates", word_type'({stp, g}), 16'h0010);
    x(16'hC000);
    chk("mask low", rx, pw(16'hA19E));
    x(16'hA800);
    chk("masked diag", rx, pw(16'hC000));
    x(16'hC000);
    x(16'hD000);
    chk("gate diag", rx, pw(16'hC01E));
    x(16'hE000);
    chk("ov diag", rx, pw(16'hD60A));
    x(16'h9000);
    chk("supply diag", rx, pw(16'hE6CE));
    x(16'hBF9E);
    chk("verify", rx, pw(16'h9032));
    x(16'hB000);
    x(16'h0000);
    chk("mask high", rx, pw(16'hB79E));
    x(16'h0000);
    chk("status", rx, pw(16'h8C9C));
    {flt, gsl, dsh} = '0;
    x(16'hF800, 1'b1);
    x(16'hF000);
    chk("frame error", rx, pw(16'h2000));
    x(16'hF900);
    chk("control kept", rx, pw(16'hF08C));
    flt[1] = 1'b1;
    repeat (10) @(negedge clk);
    chk("boot off run on", word_type'({bme, stp}), 16'h0000);
    x(16'hF880);
    chk("halt", word_type'(stp), 16'h0001);
    results;
  end
endmodule
